// >>> adc_sfr_control.sv
// Register interface and conversion sequencer of the on-chip converter
// ==========================================================================
`timescale 1ns/10ps
`default_nettype none
`include "adc_sfr_cfg.svh"

module adc_sfr_control #(
  parameter int TW = 16,
  parameter int CONV_NS = 2300
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  input  wire adc_sfr_pkg::sfr_req_t    sfr_req_i,
  input  wire logic                     conv_done_i,
  input  wire logic [11:0]              conv_data_i,
  output logic      [7:0]               sfr_rdata_o,
  output logic                          conversion_done_irq_o,
  output adc_sfr_pkg::analog_ctrl_t     analog_ctrl_o
);

  // ==========================================================================
  // Timing counts
  localparam logic [TW-1:0] ACQ0 = TW'(`CYC(`TACQ0_NS));
  localparam logic [TW-1:0] ACQ1 = TW'(`CYC(`TACQ1_NS));
  localparam logic [TW-1:0] ACQ2 = TW'(`CYC(`TACQ2_NS));
  localparam logic [TW-1:0] ACQ3 = TW'(`CYC(`TACQ3_NS));
  localparam logic [TW-1:0] PDD1 = TW'(`CYC(`PDD1_NS));
  localparam logic [TW-1:0] PDD2 = TW'(`CYC(`PDD2_NS));
  localparam logic [TW-1:0] RT0  = TW'(`RATE0_NS / `CLK_PERIOD_NS);
  localparam logic [TW-1:0] RT1  = TW'(`RATE1_NS / `CLK_PERIOD_NS);
  localparam logic [TW-1:0] RT2  = TW'(`RATE2_NS / `CLK_PERIOD_NS);
  localparam logic [TW-1:0] RT3  = TW'(`RATE3_NS / `CLK_PERIOD_NS);
  localparam logic [TW-1:0] CONV = TW'(`CYC(CONV_NS));
  localparam logic [TW-1:0] BUSYD = TW'(`BUSY_DELAY_CYC - 1);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]               pwr_cfg;
    logic [7:0]               mode_cfg;
    logic [7:0]               range_cfg;
    adc_sfr_pkg::conv_state_t st;
    logic                     busy;
    logic                     standby;
    logic                     irq;
    logic [7:0]               rdata;
    logic [TW-1:0]            period;
    logic                     done_meta;
    logic                     done_sync;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  logic        timer_load;
  logic [TW-1:0] timer_count;
  logic        timer_done;
  logic        result_load;
  logic [15:0] result;
  logic        uflow;
  logic        oflow;

  adc_cycle_timer #(
    .WIDTH (TW)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (timer_load),
    .count_i    (timer_count),
    .done_o     (timer_done)
  );

  adc_result_format u_format (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (result_load),
    .raw_i      (conv_data_i),
    .resol_i    (s.range_cfg[`RESOL_HI:`RESOL_LO]),
    .rljust_i   (s.range_cfg[`RLJUST_BIT]),
    .result_o   (result),
    .uflow_o    (uflow),
    .oflow_o    (oflow)
  );

  // ==========================================================================
  // Decoded fields
  logic       cont;
  logic [2:0] rate;
  logic [1:0] tacq;
  logic [TW-1:0] acq_cycles;
  logic [TW-1:0] rate_cycles;
  logic [TW-1:0] pdd_cycles;
  logic       start_wr;

  always_comb begin
    cont   = s.mode_cfg[`CONT_BIT];
    rate   = s.mode_cfg[`RATE_HI:`RATE_LO];
    tacq   = s.mode_cfg[`TACQ_HI:`TACQ_LO];
    unique case (tacq)
      2'h0:    acq_cycles = ACQ0;
      2'h1:    acq_cycles = ACQ1;
      2'h2:    acq_cycles = ACQ2;
      default: acq_cycles = ACQ3;
    endcase
    // Reserved rate codes fall back to the slowest rate
    unique case (rate)
      3'h1:    rate_cycles = RT1;
      3'h2:    rate_cycles = RT2;
      3'h3:    rate_cycles = RT3;
      default: rate_cycles = RT0;
    endcase
    unique case (rate)
      3'h1:    pdd_cycles = PDD1;
      3'h2:    pdd_cycles = PDD2;
      default: pdd_cycles = '0;
    endcase
    start_wr = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_POWER_CHANNEL)
               && sfr_req_i.wdata[`PWR_BIT];
  end

  // ==========================================================================
  // Sequencer and registers
  always_comb begin
    next_s      = s;
    next_s.irq  = 1'b0;
    timer_load  = 1'b0;
    timer_count = '0;
    result_load = 1'b0;

    // Analog done crosses in through two flops; data is held while done stands
    next_s.done_meta = conv_done_i;
    next_s.done_sync = s.done_meta;

    // Register writes; read-only and unused bits masked
    if (sfr_req_i.wr) begin
      unique case (sfr_req_i.addr)
        `ADDR_POWER_CHANNEL: next_s.pwr_cfg = sfr_req_i.wdata & `POWER_WMASK;
        `ADDR_MODE_TIMING:   next_s.mode_cfg = sfr_req_i.wdata & `MODE_WMASK;
        `ADDR_RANGE_RES:     next_s.range_cfg = sfr_req_i.wdata & `RANGE_WMASK;
        default: ;
      endcase
    end

    // Continuous period counter runs beside the phase timer
    if (s.period != '0) begin
      next_s.period = s.period - 1'b1;
    end

    unique case (s.st)
      adc_sfr_pkg::ST_IDLE: ;
      adc_sfr_pkg::ST_DELAY: begin
        if (timer_done) begin
          next_s.busy = 1'b1;
          next_s.st   = adc_sfr_pkg::ST_ACQ;
          timer_load  = 1'b1;
          timer_count = acq_cycles;
        end
      end
      adc_sfr_pkg::ST_ACQ: begin
        if (timer_done) begin
          next_s.st   = adc_sfr_pkg::ST_CONV;
          timer_load  = 1'b1;
          timer_count = CONV;
        end
      end
      adc_sfr_pkg::ST_CONV: begin
        if (timer_done && s.done_sync) begin
          result_load = 1'b1;
          next_s.busy = 1'b0;
          next_s.irq  = 1'b1;
          if (cont) begin
            next_s.st = adc_sfr_pkg::ST_RATEWT;
          end else if (rate == `RATE_STANDBY) begin
            next_s.standby = 1'b1;
            next_s.st      = adc_sfr_pkg::ST_IDLE;
          end else begin
            next_s.standby = 1'b1;
            next_s.st      = adc_sfr_pkg::ST_PDWAIT;
            timer_load     = 1'b1;
            timer_count    = pdd_cycles;
          end
        end
      end
      adc_sfr_pkg::ST_PDWAIT: begin
        if (timer_done) begin
          next_s.standby = 1'b0;
          next_s.st      = adc_sfr_pkg::ST_IDLE;
        end
      end
      adc_sfr_pkg::ST_RATEWT: begin
        if (s.period == '0 || s.period == {{(TW-1){1'b0}}, 1'b1}) begin
          next_s.st     = adc_sfr_pkg::ST_DELAY;
          next_s.period = rate_cycles;
          timer_load    = 1'b1;
          timer_count   = BUSYD;
        end
      end
      default: next_s.st = adc_sfr_pkg::ST_IDLE;
    endcase

    // Start write aborts anything in flight
    if (start_wr) begin
      next_s.st     = adc_sfr_pkg::ST_DELAY;
      next_s.busy   = 1'b0;
      next_s.irq    = 1'b0;
      next_s.period = rate_cycles;
      timer_load    = 1'b1;
      timer_count   = BUSYD;
      result_load   = 1'b0;
    end

    // Clearing power stops everything, standby included
    if (!next_s.pwr_cfg[`PWR_BIT]) begin
      next_s.st      = adc_sfr_pkg::ST_IDLE;
      next_s.busy    = 1'b0;
      next_s.standby = 1'b0;
      next_s.irq     = 1'b0;
      result_load    = 1'b0;
    end

    // Read data registered for a one-cycle read latency
    next_s.rdata = 8'h00;
    if (sfr_req_i.rd) begin
      unique case (sfr_req_i.addr)
        `ADDR_POWER_CHANNEL: begin
          next_s.rdata = s.pwr_cfg;
          next_s.rdata[`BUSY_BIT] = s.busy;
        end
        `ADDR_MODE_TIMING: next_s.rdata = s.mode_cfg;
        `ADDR_RANGE_RES: begin
          next_s.rdata = s.range_cfg;
          next_s.rdata[`UFLOW_BIT] = uflow;
          next_s.rdata[`OFLOW_BIT] = oflow;
          next_s.rdata[`RANGE_BIT] = uflow | oflow;
        end
        `ADDR_RESULT_HIGH: next_s.rdata = result[15:8];
        `ADDR_RESULT_LOW:  next_s.rdata = result[7:0];
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s.pwr_cfg   <= `REG_RESET;
      s.mode_cfg  <= `REG_RESET;
      s.range_cfg <= `REG_RESET;
      s.st        <= adc_sfr_pkg::ST_IDLE;
      s.busy      <= 1'b0;
      s.standby   <= 1'b0;
      s.irq       <= 1'b0;
      s.rdata     <= 8'h00;
      s.period    <= '0;
      s.done_meta <= 1'b0;
      s.done_sync <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      analog_ctrl_o <= '0;
    end else begin
      analog_ctrl_o.power_up    <= next_s.busy || next_s.st == adc_sfr_pkg::ST_DELAY;
      analog_ctrl_o.standby     <= next_s.standby;
      analog_ctrl_o.analog_pins <= next_s.pwr_cfg[`PWR_BIT];
      analog_ctrl_o.sample      <= next_s.st == adc_sfr_pkg::ST_ACQ;
      analog_ctrl_o.convert     <= next_s.st == adc_sfr_pkg::ST_CONV;
      analog_ctrl_o.channel     <= next_s.pwr_cfg[`CHSEL_HI:`CHSEL_LO];
      analog_ctrl_o.reference   <= next_s.pwr_cfg[`REFSEL_HI:`REFSEL_LO];
      analog_ctrl_o.diff_mode   <= next_s.mode_cfg[`DIFFM_HI:`DIFFM_LO];
      analog_ctrl_o.resolution  <= next_s.range_cfg[`RESOL_HI:`RESOL_LO];
    end
  end

  assign sfr_rdata_o           = s.rdata;
  assign conversion_done_irq_o = s.irq;

endmodule : adc_sfr_control
`default_nettype wire

// >>> adc_sfr_cfg.svh
// Register map, field positions and timing constants of the converter control block
`ifndef ADC_SFR_CFG_SVH
`define ADC_SFR_CFG_SVH

// ==========================================================================
// Register addresses
`define ADDR_RANGE_RES      8'hD1
`define ADDR_MODE_TIMING    8'hD2
`define ADDR_POWER_CHANNEL  8'hD3
`define ADDR_RESULT_HIGH    8'hD4
`define ADDR_RESULT_LOW     8'hD5
`define REG_RESET           8'h00

// ==========================================================================
// Field positions
`define PWR_BIT             7
`define BUSY_BIT            6
`define CHSEL_HI            5
`define CHSEL_LO            2
`define REFSEL_HI           1
`define REFSEL_LO           0
`define DIFFM_HI            7
`define DIFFM_LO            6
`define CONT_BIT            5
`define RATE_HI             4
`define RATE_LO             2
`define TACQ_HI             1
`define TACQ_LO             0
`define RESOL_HI            7
`define RESOL_LO            6
`define RLJUST_BIT          5
`define UFLOW_BIT           4
`define OFLOW_BIT           3
`define RANGE_BIT           2
`define POWER_WMASK         8'hBF
`define MODE_WMASK          8'hFF
`define RANGE_WMASK         8'hE0

// ==========================================================================
// Codes
`define RATE_STANDBY        3'h3
`define RESOL_6             2'h0
`define RESOL_8             2'h1
`define RESOL_10            2'h2

// ==========================================================================
// Timing, in ns except the busy delay in cycles, and clock period
`define CLK_PERIOD_NS       20
`define BUSY_DELAY_CYC      4
`define TACQ0_NS            750
`define TACQ1_NS            3000
`define TACQ2_NS            12000
`define TACQ3_NS            36000
`define PDD1_NS             6000
`define PDD2_NS             24000
`define RATE0_NS            500000
`define RATE1_NS            250000
`define RATE2_NS            125000
`define RATE3_NS            62500
`define CYC(ns)             (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> adc_sfr_pkg.sv
// Types shared by the converter control block
`default_nettype none
package adc_sfr_pkg;

  // ==========================================================================
  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // ==========================================================================
  // Analog core control
  typedef struct packed {
    logic       power_up;
    logic       standby;
    logic       analog_pins;
    logic       sample;
    logic       convert;
    logic [3:0] channel;
    logic [1:0] reference;
    logic [1:0] diff_mode;
    logic [1:0] resolution;
  } analog_ctrl_t;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_DELAY   = 6'b000010,
    ST_ACQ     = 6'b000100,
    ST_CONV    = 6'b001000,
    ST_PDWAIT  = 6'b010000,
    ST_RATEWT  = 6'b100000
  } conv_state_t;

endpackage : adc_sfr_pkg
`default_nettype wire

// >>> adc_result_format.sv
// Justifies a raw conversion word into the result register pair
`timescale 1ns/10ps
`default_nettype none
`include "adc_sfr_cfg.svh"

module adc_result_format (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        load_i,
  input  wire logic [11:0] raw_i,
  input  wire logic [1:0]  resol_i,
  input  wire logic        rljust_i,
  output logic      [15:0] result_o,
  output logic             uflow_o,
  output logic             oflow_o
);

  // ==========================================================================
  // Width masking
  logic [11:0] right;
  logic [15:0] justified;
  logic [11:0] all_ones;

  always_comb begin
    unique case (resol_i)
      `RESOL_6:  all_ones = 12'h03F;
      `RESOL_8:  all_ones = 12'h0FF;
      `RESOL_10: all_ones = 12'h3FF;
      default:   all_ones = 12'hFFF;
    endcase
    // Raw word is right aligned; unused bits forced to zero
    right = raw_i & all_ones;
    if (rljust_i) begin
      justified = {4'h0, right};
    end else begin
      unique case (resol_i)
        `RESOL_6:  justified = {right[5:0], 10'h000};
        `RESOL_8:  justified = {right[7:0], 8'h00};
        `RESOL_10: justified = {right[9:0], 6'h00};
        default:   justified = {right, 4'h0};
      endcase
    end
  end

  // ==========================================================================
  // Registered result and range flags
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_o <= 16'h0000;
      uflow_o  <= 1'b0;
      oflow_o  <= 1'b0;
    end else if (load_i) begin
      result_o <= justified;
      uflow_o  <= (right == 12'h000);
      oflow_o  <= (right == all_ones);
    end
  end

endmodule : adc_result_format
`default_nettype wire

// >>> adc_cycle_timer.sv
// Down counter that times each phase of a conversion
`timescale 1ns/10ps
`default_nettype none

module adc_cycle_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] count;

  // Done is a level while the count rests at zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count  <= '0;
      done_o <= 1'b1;
    end else if (load_i) begin
      count  <= count_i;
      done_o <= (count_i == '0);
    end else if (count != '0) begin
      count  <= count - 1'b1;
      done_o <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

endmodule : adc_cycle_timer
`default_nettype wire

// >>> adc_analog_model.sv
// Behavioural analog core facing the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_analog_model (
  input  wire logic                      core_clk_i,
  input  wire adc_sfr_pkg::analog_ctrl_t ctrl_i,
  input  wire logic [11:0]               value_i,
  input  wire logic [7:0]                lag_i,
  output logic                           done_o,
  output logic [11:0]                    data_o
);
  // ====================
  // Answer after lag_i cycles of convert
  int cnt;
  initial begin
    cnt    = 0;
    done_o = 1'b0;
    data_o = 12'h5A5;
  end
  always @(posedge core_clk_i) begin
    if (!ctrl_i.convert) begin
      cnt    <= 0;
      done_o <= 1'b0;
      // Stale data toggles so it never passes for a result
      data_o <= ~data_o;
    end else if (cnt < int'(lag_i)) begin
      cnt <= cnt + 1;
    end else begin
      done_o <= 1'b1;
      data_o <= value_i;
    end
  end
endmodule : adc_analog_model
`default_nettype wire

// >>> adc_sfr_checker.sv
// Port checks of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_sfr_checker #(
  parameter int TW      = 16,
  parameter int CONV_NS = 2300
) (
  input wire logic                      core_clk_i,
  input wire logic                      rstn_i,
  input wire adc_sfr_pkg::sfr_req_t     sfr_req_i,
  input wire logic                      conv_done_i,
  input wire logic [11:0]               conv_data_i,
  input wire logic [7:0]                sfr_rdata_o,
  input wire logic                      conversion_done_irq_o,
  input wire adc_sfr_pkg::analog_ctrl_t analog_ctrl_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic wr1;
  logic wr2;
  logic wr3;
  assign wr1 = sfr_req_i.wr && sfr_req_i.addr == 8'hD1;
  assign wr2 = sfr_req_i.wr && sfr_req_i.addr == 8'hD2;
  assign wr3 = sfr_req_i.wr && sfr_req_i.addr == 8'hD3;
  // ====================
  // Properties
  property p_rd_idle;
    !sfr_req_i.rd |=> sfr_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero without a read");
  property p_unmapped;
    sfr_req_i.rd && !(sfr_req_i.addr inside {[8'hD1:8'hD5]}) |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_irq_pulse;
    $rose(conversion_done_irq_o) |=> !conversion_done_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("done pulse longer than one cycle");
  property p_pwr_on;
    wr3 && sfr_req_i.wdata[7] |=> analog_ctrl_o.analog_pins;
  endproperty
  a_pwr_on: assert property (p_pwr_on)
    else $error("pins not analog after power up");
  property p_pwr_off;
    wr3 && !sfr_req_i.wdata[7] |=> !analog_ctrl_o.power_up && !analog_ctrl_o.analog_pins;
  endproperty
  a_pwr_off: assert property (p_pwr_off)
    else $error("converter still powered after power down");
  property p_off_no_irq;
    wr3 && !sfr_req_i.wdata[7] |=> !conversion_done_irq_o;
  endproperty
  a_off_no_irq: assert property (p_off_no_irq)
    else $error("done pulse after power down");
  property p_chan;
    wr3 |=> {analog_ctrl_o.channel, analog_ctrl_o.reference} == $past(sfr_req_i.wdata[5:0]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel or reference differs from write");
  property p_diff;
    wr2 |=> analog_ctrl_o.diff_mode == $past(sfr_req_i.wdata[7:6]);
  endproperty
  a_diff: assert property (p_diff)
    else $error("input mode differs from write");
  property p_resol;
    wr1 |=> analog_ctrl_o.resolution == $past(sfr_req_i.wdata[7:6]);
  endproperty
  a_resol: assert property (p_resol)
    else $error("resolution differs from write");
  property p_irq_pins;
    conversion_done_irq_o |-> analog_ctrl_o.analog_pins;
  endproperty
  a_irq_pins: assert property (p_irq_pins)
    else $error("pins left analog mode at conversion end");
  c_irq: cover property (conversion_done_irq_o);
  c_start: cover property (wr3 && sfr_req_i.wdata[7]);
  c_res: cover property (sfr_req_i.rd && sfr_req_i.addr == 8'hD4);
endmodule : adc_sfr_checker
`default_nettype wire

// >>> tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                      core_clk_i;
  logic                      rstn_i;
  adc_sfr_pkg::sfr_req_t     req;
  logic                      done;
  logic [11:0]               data;
  logic [7:0]                rdata;
  logic                      irq;
  adc_sfr_pkg::analog_ctrl_t ctrl;
  logic [11:0]               value;
  logic [7:0]                lag;
  logic [31:0]               seed;
  int                        miscompares;
  int                        cmp_count;
  int                        irqs;
  int                        acq[4] = '{38, 150, 600, 1800};
  adc_sfr_control u_adc_sfr_control (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_req_i(req),
    .conv_done_i(done), .conv_data_i(data), .sfr_rdata_o(rdata), .conversion_done_irq_o(irq),
    .analog_ctrl_o(ctrl));
  adc_analog_model u_adc_analog_model (.core_clk_i(core_clk_i), .ctrl_i(ctrl), .value_i(value),
    .lag_i(lag), .done_o(done), .data_o(data));
  // ====================
  // Clock and helpers
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) begin
    if (irq === 1'b1) irqs++;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick
  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    tick(1);
    // Strobe low across one edge before the next call raises it
    req.wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    req.rd   = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    chk($sformatf("reg %h", a), e, rdata);
    tick(1);
  endtask : rd_chk
  task automatic wait_irq(output int lat);
    lat = 0;
    while (irq !== 1'b1) begin
      tick(1);
      lat++;
      if (lat > 5000) begin
        chk("irq", 1'b1, irq);
        print_verdict();
      end
    end
  endtask : wait_irq
  // ====================
  // Main sequence
  initial begin
    int          n;
    int          lat;
    int          n0;
    logic [15:0] m;
    logic [15:0] v;
    logic [15:0] word;
    logic [7:0]  c1;
    req         = '0;
    rstn_i      = 1'b0;
    value       = 12'h000;
    lag         = 8'h00;
    seed        = 32'h2F5E;
    miscompares = 0;
    cmp_count   = 0;
    irqs        = 0;
    tick(10);
    rstn_i = 1'b1;
    for (int a = 8'hD0; a <= 8'hD6; a++) rd_chk(8'(a), 8'h00);
    wr(8'hD3, 8'h7F);
    rd_chk(8'hD3, 8'h3F);
    wr(8'hD1, 8'hFF);
    rd_chk(8'hD1, 8'hE0);
    wr(8'hD4, 8'hA5);
    wr(8'hD5, 8'h5A);
    rd_chk(8'hD4, 8'h00);
    rd_chk(8'hD5, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(8'hD2, seed[7:0]);
      rd_chk(8'hD2, seed[7:0]);
    end
    // Every resolution, both justifications, prompt and slow core
    for (int i = 0; i < 8; i++) begin
      seed  = lfsr(seed);
      value = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : seed[11:0];
      lag   = i[0] ? 8'hC8 : 8'h00;
      c1    = {i[1:0], i[2], 5'h00};
      wr(8'hD1, c1);
      wr(8'hD2, {i[1:0], 2'b00, i[1:0], i[1:0]});
      wr(8'hD3, {2'b10, seed[17:12]});
      // Busy low at the reads two and four edges after the start
      rd_chk(8'hD3, {2'b10, seed[17:12]});
      rd_chk(8'hD3, {2'b10, seed[17:12]});
      rd_chk(8'hD3, {2'b11, seed[17:12]});
      wait_irq(lat);
      chk("latency", 1'b1, lat >= acq[i % 4] + 110 && lat <= acq[i % 4] + int'(lag) + 160);
      n    = 6 + 2 * (i % 4);
      m    = 16'((1 << n) - 1);
      v    = 16'(value) & m;
      word = i[2] ? v : 16'(v << (16 - n));
      rd_chk(8'hD3, {2'b10, seed[17:12]});
      rd_chk(8'hD4, word[15:8]);
      rd_chk(8'hD5, word[7:0]);
      rd_chk(8'hD1, {c1[7:5], v == 16'h0, v == m, v == 16'h0 || v == m, 2'b00});
      chk("analog_pins", 1'b1, ctrl.analog_pins);
      chk("standby", i % 4 != 0, ctrl.standby);
      chk("active", 3'b000, {ctrl.power_up, ctrl.sample, ctrl.convert});
    end
    wr(8'hD2, 8'h00);
    wr(8'hD3, 8'h80);
    tick(20);
    n0 = irqs;
    wr(8'hD3, 8'h80);
    rd_chk(8'hD3, 8'h80);
    wait_irq(lat);
    tick(400);
    chk("abort irqs", 16'(n0 + 1), 16'(irqs));
    wr(8'hD3, 8'h80);
    tick(20);
    n0 = irqs;
    wr(8'hD3, 8'h00);
    tick(400);
    chk("off irqs", 16'(n0), 16'(irqs));
    rd_chk(8'hD3, 8'h00);
    wr(8'hD2, 8'h2C);
    lag = 8'h00;
    n0  = irqs;
    wr(8'hD3, 8'h80);
    tick(6500);
    chk("cont irqs", 16'(n0 + 3), 16'(irqs));
    wr(8'hD3, 8'h00);
    print_verdict();
  end
endmodule : tb
bind adc_sfr_control adc_sfr_checker #(.TW(TW), .CONV_NS(CONV_NS)) u_adc_sfr_checker (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_req_i(sfr_req_i), .conv_done_i(conv_done_i),
  .conv_data_i(conv_data_i), .sfr_rdata_o(sfr_rdata_o),
  .conversion_done_irq_o(conversion_done_irq_o), .analog_ctrl_o(analog_ctrl_o));
`default_nettype wire
